// File: inc/asc_map.vh
// field positions, status bit positions and timing counts of the serial channel
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
`define ASC_MR_LEN_LO   0
`define ASC_MR_LEN_HI   1
`define ASC_MR_PTYPE    2
`define ASC_MR_PMODE_LO 3
`define ASC_MR_PMODE_HI 4
`define ASC_MR_ERRMODE  5
`define ASC_MR_RXISEL   6
`define ASC_PM_WITH     2'b00
`define ASC_PM_NONE     2'b10
`define ASC_ST_RECEIVE_CHAR_AVAILABLE    0
`define ASC_ST_RECEIVE_QUEUE_FULL    1
`define ASC_ST_TXRDY    2
`define ASC_ST_TXEMT    3
`define ASC_ST_OE       4
`define ASC_ST_PE       5
`define ASC_ST_FE       6
`define ASC_ST_BRK      7
`define ASC_MIN_BITS    4'h5
`define ASC_OVS_LAST    4'hf
`define ASC_START_SMP   4'h7
`define ASC_RXQ_DEPTH   3
`endif

// File: core/asc_tx.v
// transmit shift register: frames and serialises one character per load
`timescale 1ns/1ns
`default_nettype none
`include "asc_map.vh"
module asc_tx #(
    parameter FW = 12
) (
    input  wire       clk_i,        // system clock
    input  wire       nrst_i,       // async reset, active low
    input  wire       bit_clock_i,  // transmit_bit_clock from timing block
    input  wire       mode_16x_i,   // 1: bit clock is 16x
    input  wire       hold_valid_i, // holding register has a character
    input  wire [7:0] hold_data_i,  // holding register character
    input  wire [7:0] mode_i,       // mode_register_one
    input  wire       two_stop_i,   // 1: two stop bits
    output wire       take_o,       // holding register is emptied now
    output wire       busy_o,       // shift register holds a character
    output wire       serial_o      // serial_out
);
    reg          clk_d_r;
    reg  [3:0]   div_r;
    reg          busy_r;
    reg          ser_r;
    reg  [FW-1:0] frame_r;
    reg  [3:0]   left_r;
    reg  [FW-1:0] frame_nxt;
    reg  [3:0]   len_nxt;
    reg  [3:0]   nb;
    reg          par_on;
    reg          pbit;
    integer      i;
    wire         edge_w = bit_clock_i & ~clk_d_r;
    wire         tick = edge_w & (~mode_16x_i | (div_r == `ASC_OVS_LAST));
    wire         done = ~busy_r | (left_r == 4'h0);

    assign take_o   = tick & done & hold_valid_i;
    assign busy_o   = busy_r;
    assign serial_o = ser_r;

    always @* begin
        nb     = `ASC_MIN_BITS + {2'b00, mode_i[`ASC_MR_LEN_HI:`ASC_MR_LEN_LO]};
        par_on = mode_i[`ASC_MR_PMODE_HI:`ASC_MR_PMODE_LO] != `ASC_PM_NONE;
        pbit   = mode_i[`ASC_MR_PTYPE];
        // with parity: even keeps the ones count even, odd flips it; force sends the bit
        if (mode_i[`ASC_MR_PMODE_HI:`ASC_MR_PMODE_LO] == `ASC_PM_WITH) begin
            pbit = mode_i[`ASC_MR_PTYPE];
            for (i = 0; i < 8; i = i + 1) begin
                if (i < nb)
                    pbit = pbit ^ hold_data_i[i];
            end
        end
        frame_nxt    = {FW{1'b1}};
        frame_nxt[0] = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            if (i < nb)
                frame_nxt[i+1] = hold_data_i[i];
        end
        if (par_on)
            frame_nxt[nb+4'h1] = pbit;
        len_nxt = nb + 4'h2 + {3'b000, par_on} + {3'b000, two_stop_i};
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_d_r <= 1'b0;
            div_r   <= 4'h0;
            busy_r  <= 1'b0;
            ser_r   <= 1'b1;
            frame_r <= {FW{1'b1}};
            left_r  <= 4'h0;
        end else begin
            clk_d_r <= bit_clock_i;
            if (edge_w)
                div_r <= div_r + 4'h1;
            if (tick) begin
                if (!done) begin
                    ser_r   <= frame_r[0];
                    frame_r <= {1'b1, frame_r[FW-1:1]};
                    left_r  <= left_r - 4'h1;
                end else if (hold_valid_i) begin
                    // next character follows the last stop bit with no idle gap
                    ser_r   <= frame_nxt[0];
                    frame_r <= {1'b1, frame_nxt[FW-1:1]};
                    left_r  <= len_nxt - 4'h1;
                    busy_r  <= 1'b1;
                end else begin
                    ser_r  <= 1'b1;
                    busy_r <= 1'b0;
                end
            end
        end
    end
endmodule // asc_tx
`default_nettype wire

// File: core/asc_fifo.v
// small synchronous fifo used as the receive holding queue
`timescale 1ns/1ns
`default_nettype none
module asc_fifo #(
    parameter W  = 11,
    parameter D  = 3,
    parameter AW = 2
) (
    input  wire         clk_i,   // system clock
    input  wire         nrst_i,  // async reset, active low
    input  wire         push_i,  // write an entry
    input  wire [W-1:0] din_i,   // entry written
    input  wire         pop_i,   // drop the top entry
    output wire [W-1:0] dout_o,  // top entry
    output wire         empty_o, // no entry
    output wire         full_o   // all entries used
);
    reg  [W-1:0] mem [0:D-1];
    reg  [AW-1:0] wp_r;
    reg  [AW-1:0] rp_r;
    reg  [AW:0]   cnt_r;
    wire          do_pop  = pop_i & (cnt_r != {(AW+1){1'b0}});
    wire          do_push = push_i & (cnt_r != D[AW:0]);

    assign dout_o  = mem[rp_r];
    assign empty_o = cnt_r == {(AW+1){1'b0}};
    assign full_o  = cnt_r == D[AW:0];

    always @(posedge clk_i) begin
        if (do_push)
            mem[wp_r] <= din_i;
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (do_push)
                wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            if (do_pop)
                rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            cnt_r <= cnt_r + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
        end
    end
endmodule // asc_fifo
`default_nettype wire

// File: core/asc_channel.v
// one asynchronous serial channel: holding register, transmitter, receiver, status
// What this block does
// - serial output stays high while the transmitter is idle or inactive.
// - each character begins with one low start bit period.
// - data bits follow the start bit, least significant first.
// - optional parity bit sits between last data bit and stop bit.
// - cpu writes the one-entry holding register, which feeds the shift register.
// - transmit interrupt when mask set and holding and shift registers empty.
// - after disable, remaining characters are still sent until both registers empty.
// - after disable, writes to the holding register are refused.
// - received characters enter a three-entry queue; a cpu read pops the top.
// - 16x mode: start bit valid only if still low at the 7th sample.
// - later bits are sampled one bit period apart from the 7th sample.
// - start-bit oversampling and alignment repeat for every start bit.
// - after last data bit check parity, sample stop; good mark completes character.
// - stop bit sampled as space sets the framing error flag, status bit 6.
// - wrong parity on a received character sets status bit 5.
// - queue full plus waiting character plus new data: overwrite, set status bit 4.
// - all-space character with space stop is a break, status bit 7.
// - a break loads one break character then waits for mark.
// - delta-break flag and interrupt at break start and at return to mark.
// - receiver-ready is true while the queue holds a character.
// - queue-full is true while the queue cannot take another character.
// - receive interrupt from ready or full as selected, gated by its mask.
// - mode bit 6 selects receive interrupt source: 0 ready, 1 full.
// - mode bits 1:0 give 5, 6, 7 or 8 data bits.
// - mode bit 2 is parity type, or the forced value; unused without parity.
// - mode bit 5: error flags per top character, or accumulated until reset.
`timescale 1ns/1ns
`default_nettype none
`include "asc_map.vh"
module asc_channel #(
    parameter RXQ_DEPTH = `ASC_RXQ_DEPTH
) (
    input  wire       clk_i,                // system clock, 50 MHz
    input  wire       nrst_i,               // async reset, active low
    input  wire       transmit_bit_clock_i, // transmit bit clock from timing block
    input  wire       receive_bit_clock_i,  // receive bit clock from timing block
    input  wire       tx_16x_i,             // 1: transmit clock is 16x
    input  wire       rx_16x_i,             // 1: receive clock is 16x
    input  wire [7:0] mode_register_one_i,  // character format and receive options
    input  wire       two_stop_i,           // 1: two stop bits
    input  wire       tx_enable_i,          // transmitter enabled
    input  wire       rx_enable_i,          // receiver enabled
    input  wire       tx_write_i,           // write pulse to holding register
    input  wire [7:0] tx_data_i,            // character written
    input  wire       rx_read_i,            // read pulse, pops the queue top
    input  wire       error_reset_i,        // clears overrun and accumulated errors
    input  wire       tx_irq_mask_i,        // transmit interrupt mask bit
    input  wire       rx_irq_mask_i,        // receive interrupt mask bit
    input  wire       break_irq_mask_i,     // delta-break interrupt mask bit
    input  wire       delta_break_clr_i,    // clears the delta-break flag
    input  wire       serial_in_i,          // serial_in
    output reg        serial_out_o,         // serial_out
    output reg  [7:0] rx_data_o,            // top character of receive queue
    output reg  [7:0] status_o,             // channel_status_register
    output reg        delta_break_o,        // sticky delta-break flag
    output reg        tx_irq_o,             // transmit interrupt request
    output reg        rx_irq_o,             // receive interrupt request
    output reg        break_irq_o           // delta-break interrupt request
);
    // receive sequencer states
    localparam ST_IDLE  = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_DATA  = 2'd2;
    localparam ST_BRK   = 2'd3;

    // holding register
    reg        thr_full_r;
    reg  [7:0] thr_data_r;
    wire       tx_take;
    wire       tsr_busy;
    wire       tx_ser;

    // receiver
    reg        rx_clk_d_r;
    reg  [1:0] rx_st_r;
    reg  [1:0] rx_st_nxt;
    reg  [3:0] ph_r;
    reg  [3:0] ph_nxt;
    reg  [3:0] bit_r;
    reg  [3:0] bit_nxt;
    reg  [9:0] sh_r;
    reg  [9:0] sh_nxt;
    reg        done_nxt;
    reg        brk_start;
    reg        brk_end;
    reg        rsr_full_r;
    reg [10:0] rsr_data_r;
    reg        oe_r;
    reg  [2:0] err_acc_r;

    // received character decode
    reg  [3:0] nb;
    reg        par_on;
    reg  [3:0] last_idx;
    reg  [7:0] rx_char;
    reg        exp_par;
    reg        got_par;
    reg        all_space;
    reg        pe_now;
    reg        fe_now;
    integer    i;

    wire       rx_tick = receive_bit_clock_i & ~rx_clk_d_r;
    wire       smp_now = rx_tick & (~rx_16x_i | (ph_r == `ASC_OVS_LAST));
    wire       q_full;
    wire       q_empty;
    wire [10:0] q_top;
    wire       rsr_move = rsr_full_r & ~q_full;
    // multi-drop code is handled as forced parity; no address wake-up here
    wire [1:0] pmode = mode_register_one_i[`ASC_MR_PMODE_HI:`ASC_MR_PMODE_LO];
    wire [2:0] top_err = q_empty ? 3'b000 : q_top[10:8];
    wire [2:0] err_show;

    // write is taken only while enabled and the single entry is free
    wire       thr_wr = tx_write_i & tx_enable_i & ~thr_full_r;

    asc_tx #(
        .FW (12)
    ) u_tx (
        .clk_i        (clk_i),
        .nrst_i       (nrst_i),
        .bit_clock_i  (transmit_bit_clock_i),
        .mode_16x_i   (tx_16x_i),
        .hold_valid_i (thr_full_r),
        .hold_data_i  (thr_data_r),
        .mode_i       (mode_register_one_i),
        .two_stop_i   (two_stop_i),
        .take_o       (tx_take),
        .busy_o       (tsr_busy),
        .serial_o     (tx_ser)
    );

    // holding register drains into the shift register even after disable
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            thr_full_r <= 1'b0;
            thr_data_r <= 8'h00;
        end else begin
            if (thr_wr) begin
                thr_full_r <= 1'b1;
                thr_data_r <= tx_data_i;
            end else if (tx_take) begin
                thr_full_r <= 1'b0;
            end
        end
    end

    asc_fifo #(
        .W  (11),
        .D  (RXQ_DEPTH),
        .AW (2)
    ) u_rxq (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .push_i  (rsr_move),
        .din_i   (rsr_data_r),
        .pop_i   (rx_read_i),
        .dout_o  (q_top),
        .empty_o (q_empty),
        .full_o  (q_full)
    );

    // decode of the bits gathered so far; used on the stop sample
    always @* begin
        nb       = `ASC_MIN_BITS + {2'b00, mode_register_one_i[`ASC_MR_LEN_HI:`ASC_MR_LEN_LO]};
        par_on   = pmode != `ASC_PM_NONE;
        last_idx = nb + {3'b000, par_on};
        rx_char  = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            if (i < nb)
                rx_char[i] = sh_r[i];
        end
        got_par = sh_r[nb];
        exp_par = mode_register_one_i[`ASC_MR_PTYPE];
        if (pmode == `ASC_PM_WITH)
            exp_par = exp_par ^ (^rx_char);
        pe_now    = par_on & (got_par != exp_par);
        fe_now    = ~serial_in_i;
        all_space = (rx_char == 8'h00) & ~(par_on & got_par) & ~serial_in_i;
    end

    // receive sequencer
    always @* begin
        rx_st_nxt = rx_st_r;
        ph_nxt    = ph_r;
        bit_nxt   = bit_r;
        sh_nxt    = sh_r;
        done_nxt  = 1'b0;
        brk_start = 1'b0;
        brk_end   = 1'b0;
        case (rx_st_r)
            ST_IDLE: begin
                // looks for a start right after a stop sample, so a space stop
                // that lasts past the 7th sample opens a new frame
                if (rx_enable_i & rx_tick & ~serial_in_i) begin
                    bit_nxt = 4'h0;
                    if (rx_16x_i) begin
                        rx_st_nxt = ST_START;
                        ph_nxt    = 4'h1;
                    end else begin
                        rx_st_nxt = ST_DATA;
                    end
                end
            end
            ST_START: begin
                if (rx_tick) begin
                    ph_nxt = ph_r + 4'h1;
                    if (ph_r == `ASC_START_SMP - 4'h1) begin
                        // a pulse gone high by now was noise
                        if (serial_in_i) begin
                            rx_st_nxt = ST_IDLE;
                        end else begin
                            rx_st_nxt = ST_DATA;
                            ph_nxt    = 4'h0;
                        end
                    end
                end
            end
            ST_DATA: begin
                if (rx_tick)
                    ph_nxt = ph_r + 4'h1;
                if (smp_now) begin
                    ph_nxt  = 4'h0;
                    bit_nxt = bit_r + 4'h1;
                    sh_nxt[bit_r] = serial_in_i;
                    if (bit_r == last_idx) begin
                        done_nxt = 1'b1;
                        if (all_space) begin
                            rx_st_nxt = ST_BRK;
                            brk_start = 1'b1;
                        end else begin
                            rx_st_nxt = ST_IDLE;
                        end
                    end
                end
            end
            ST_BRK: begin
                // no tick needed: the first clock that sees mark ends the break
                if (serial_in_i) begin
                    rx_st_nxt = ST_IDLE;
                    brk_end   = 1'b1;
                end
            end
            default: rx_st_nxt = ST_IDLE;
        endcase
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_clk_d_r <= 1'b0;
            rx_st_r    <= ST_IDLE;
            ph_r       <= 4'h0;
            bit_r      <= 4'h0;
            sh_r       <= 10'h000;
        end else begin
            rx_clk_d_r <= receive_bit_clock_i;
            rx_st_r    <= rx_st_nxt;
            ph_r       <= ph_nxt;
            bit_r      <= bit_nxt;
            sh_r       <= sh_nxt;
        end
    end

    // receive shift register slot in front of the queue
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsr_full_r <= 1'b0;
            rsr_data_r <= 11'h000;
            oe_r       <= 1'b0;
        end else begin
            if (done_nxt) begin
                rsr_full_r <= 1'b1;
                // a break stores one all-zero character flagged as break
                rsr_data_r <= {all_space, fe_now, pe_now & ~all_space, rx_char};
            end else if (rsr_move) begin
                rsr_full_r <= 1'b0;
            end
            // waiting character lost to a newer one; set wins over the reset
            if (done_nxt & rsr_full_r & q_full)
                oe_r <= 1'b1;
            else if (error_reset_i)
                oe_r <= 1'b0;
        end
    end

    // block error mode gathers flags of every character seen on top
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            err_acc_r <= 3'b000;
        end else if (error_reset_i) begin
            err_acc_r <= top_err;
        end else begin
            err_acc_r <= err_acc_r | top_err;
        end
    end

    assign err_show = mode_register_one_i[`ASC_MR_ERRMODE] ? err_acc_r : top_err;

    // registered outputs
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_out_o  <= 1'b1;
            rx_data_o     <= 8'h00;
            status_o      <= 8'h00;
            delta_break_o <= 1'b0;
            tx_irq_o      <= 1'b0;
            rx_irq_o      <= 1'b0;
            break_irq_o   <= 1'b0;
        end else begin
            serial_out_o <= tx_ser;
            // an empty queue shows zero instead of a stale or unwritten entry
            if (q_empty)
                rx_data_o <= 8'h00;
            else
                rx_data_o <= q_top[7:0];
            status_o[`ASC_ST_RECEIVE_CHAR_AVAILABLE] <= ~q_empty;
            status_o[`ASC_ST_RECEIVE_QUEUE_FULL] <= q_full;
            status_o[`ASC_ST_TXRDY] <= tx_enable_i & ~thr_full_r;
            status_o[`ASC_ST_TXEMT] <= ~thr_full_r & ~tsr_busy;
            status_o[`ASC_ST_OE]    <= oe_r;
            status_o[`ASC_ST_PE]    <= err_show[0];
            status_o[`ASC_ST_FE]    <= err_show[1];
            status_o[`ASC_ST_BRK]   <= err_show[2];
            // an edge in the clearing cycle keeps the flag set
            if (brk_start | brk_end)
                delta_break_o <= 1'b1;
            else if (delta_break_clr_i)
                delta_break_o <= 1'b0;
            break_irq_o <= break_irq_mask_i & (delta_break_o | brk_start | brk_end);
            // request ignores the enable, so a drained disabled transmitter still asks
            tx_irq_o    <= tx_irq_mask_i & ~thr_full_r & ~tsr_busy;
            rx_irq_o    <= rx_irq_mask_i &
                           (mode_register_one_i[`ASC_MR_RXISEL] ? q_full : ~q_empty);
        end
    end
endmodule // asc_channel
`default_nettype wire

// File: verification/asc_channel_asserts.sv
// concurrent checks on the serial channel ports
`timescale 1ns/1ns
`default_nettype none
module asc_channel_chk (
    input wire logic       clk_i,            // system clock
    input wire logic       nrst_i,           // async reset, active low
    input wire logic       serial_out_o,     // serial_out
    input wire logic [7:0] status_o,         // channel_status_register
    input wire logic       tx_irq_o,         // transmit request
    input wire logic       rx_irq_o,         // receive request
    input wire logic       break_irq_o,      // delta-break request
    input wire logic       tx_irq_mask_i,    // transmit mask
    input wire logic       rx_irq_mask_i,    // receive mask
    input wire logic       break_irq_mask_i, // delta-break mask
    input wire logic       error_reset_i     // error reset pulse
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_idle_mark: assert property (status_o[3] |-> serial_out_o)
        else $error("serial line not at mark while idle");
    // the bench ticks the 1x transmit clock every 8 cycles, so no low run is shorter
    a_bit_length: assert property ($fell(serial_out_o) |-> (!serial_out_o)[*8])
        else $error("low bit shorter than one bit period");
    a_tx_irq_mask: assert property (!tx_irq_mask_i |=> !tx_irq_o)
        else $error("transmit request while masked");
    a_tx_irq_busy: assert property (tx_irq_o |-> status_o[3] || $past(status_o[3]))
        else $error("transmit request while not empty");
    a_rx_irq_mask: assert property (!rx_irq_mask_i |=> !rx_irq_o)
        else $error("receive request while masked");
    a_rx_irq_src: assert property (rx_irq_o |-> status_o[0] || $past(status_o[0]))
        else $error("receive request with empty queue");
    a_brk_irq_mask: assert property (!break_irq_mask_i |=> !break_irq_o)
        else $error("delta-break request while masked");
    a_full_ready: assert property (status_o[1] |-> status_o[0])
        else $error("queue full without ready");
    a_oe_sticky: assert property (status_o[4] && !error_reset_i && !$past(error_reset_i)
        |=> status_o[4]) else $error("overrun flag lost without reset");
    cover property ($fell(serial_out_o));
    cover property ($rose(status_o[4]));
    cover property ($rose(status_o[7]));
endmodule // asc_channel_chk
bind asc_channel asc_channel_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .serial_out_o(serial_out_o), .status_o(status_o), .tx_irq_o(tx_irq_o),
    .rx_irq_o(rx_irq_o), .break_irq_o(break_irq_o), .tx_irq_mask_i(tx_irq_mask_i),
    .rx_irq_mask_i(rx_irq_mask_i), .break_irq_mask_i(break_irq_mask_i),
    .error_reset_i(error_reset_i));
`default_nettype wire

// File: verification/asc_far.sv
// far end model: sends frames into the channel and captures its output
`timescale 1ns/1ns
`default_nettype none
module asc_far #(
    parameter RX_BIT = 32, // clk cycles per bit sent into the channel
    parameter TX_BIT = 8   // clk cycles per bit sent by the channel
) (
    input  wire logic clk_i,        // system clock
    input  wire logic serial_out_i, // line from the channel
    output var  logic serial_in_o   // line into the channel
);
    logic [9:0] got[$];
    logic [9:0] f;
    initial serial_in_o = 1'b1;
    task automatic put(input logic b, input int n);
        @(posedge clk_i) #2 serial_in_o = b;
        repeat (n - 1) @(posedge clk_i);
    endtask
    // start, data lsb first, even parity (inverted when bad), stop, then mark
    task automatic send(input logic [7:0] d, input logic bad, input logic stp);
        put(1'b0, RX_BIT);
        for (int i = 0; i < 8; i++) put(d[i], RX_BIT);
        put(^d ^ bad, RX_BIT);
        // a space stop ends before the 7th sample of any start seen inside it
        put(stp, stp ? RX_BIT : RX_BIT / 2 + 8);
        put(1'b1, RX_BIT);
    endtask
    // mid-bit sampling of data, parity and stop after each falling start edge
    always begin
        @(negedge serial_out_i);
        repeat (TX_BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            repeat (TX_BIT) @(posedge clk_i);
            f[i] = serial_out_i;
        end
        got.push_back(f);
    end
endmodule // asc_far
`default_nettype wire

// File: verification/tb.sv
// self-checking bench of the serial channel
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0, nrst = 1'b0, twr = 1'b0, rrd = 1'b0, erst = 1'b0, dclr = 1'b0;
    logic ten = 1'b1, msk = 1'b0, r16 = 1'b1;
    logic [7:0] mode = 8'h43, td = 8'h00, cnt = 8'h00, d;
    wire logic sout, sin, dbrk, tirq, rirq, birq;
    wire logic [7:0] rdat, st;
    int n_mismatch = 0, checks_done = 0, seed = 51;
    logic [9:0] texp[$];
    logic [7:0] rexp[$];
    always #10 clk = ~clk;
    always @(posedge clk) cnt <= #2 cnt + 8'h01;
    asc_channel dut (.clk_i(clk), .nrst_i(nrst), .transmit_bit_clock_i(cnt[2]),
        .receive_bit_clock_i(r16 ? cnt[0] : cnt[4]), .tx_16x_i(1'b0), .rx_16x_i(r16),
        .mode_register_one_i(mode), .two_stop_i(1'b0), .tx_enable_i(ten),
        .rx_enable_i(1'b1), .tx_write_i(twr), .tx_data_i(td), .rx_read_i(rrd),
        .error_reset_i(erst), .tx_irq_mask_i(msk), .rx_irq_mask_i(msk),
        .break_irq_mask_i(msk), .delta_break_clr_i(dclr), .serial_in_i(sin),
        .serial_out_o(sout), .rx_data_o(rdat), .status_o(st), .delta_break_o(dbrk),
        .tx_irq_o(tirq), .rx_irq_o(rirq), .break_irq_o(birq));
    asc_far far (.clk_i(clk), .serial_out_i(sout), .serial_in_o(sin));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(4);
    endtask
    task automatic snd(input logic [7:0] v, input logic bad, input logic stp);
        far.send(v, bad, stp);
        cyc(2);
    endtask
    // flags are break, framing, parity of the queue top
    task automatic rd(input logic [2:0] flags);
        chk(rdat, rexp.pop_front());
        chk(st[7:5], flags);
        pulse(rrd);
    endtask
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end
    initial begin
        cyc(4);
        nrst = 1'b1;
        cyc(2);
        chk(st, 8'h0c);
        chk(sout, 1'b1);
        msk = 1'b1;
        // the third write lands after disable while two characters are still pending
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 200 && i < 2 && st[2] !== 1'b1; k++) cyc(1);
            d = 8'($random(seed));
            if (i < 2) texp.push_back({1'b1, ^d, d});
            else ten = 1'b0;
            td = d;
            pulse(twr);
        end
        cyc(400);
        chk(10'(far.got.size()), 10'd2);
        while (far.got.size() > 0) chk(far.got.pop_front(), texp.pop_front());
        chk({tirq, st[2]}, 2'b10);
        far.put(1'b0, 4);
        // long enough for an unvalidated pulse to have completed a character
        far.put(1'b1, 400);
        cyc(2);
        chk(st[0], 1'b0);
        // fourth waits behind a full queue, fifth overwrites it
        for (int i = 0; i < 5; i++) begin
            d = 8'($random(seed));
            if (i != 3) rexp.push_back(d);
            snd(d, 1'b0, 1'b1);
            if (i == 2) chk({rirq, st[1:0]}, 3'h7);
        end
        chk(st[4], 1'b1);
        rd(3'h0);
        rd(3'h0);
        chk(rirq, 1'b0);
        mode = 8'h03;
        cyc(2);
        chk(rirq, 1'b1);
        rd(3'h0);
        rd(3'h0);
        chk(st[0], 1'b0);
        // 1x receive clock: one tick per 32-cycle bit
        r16 = 1'b0;
        d = 8'($random(seed));
        rexp.push_back(d);
        snd(d, 1'b0, 1'b1);
        rd(3'h0);
        r16 = 1'b1;
        pulse(erst);
        chk(st[4], 1'b0);
        d = 8'($random(seed)) | 8'h01;
        rexp.push_back(d);
        snd(d, 1'b0, 1'b0);
        rd(3'h2);
        rexp.push_back(d);
        snd(d, 1'b1, 1'b1);
        rd(3'h1);
        far.put(1'b0, 420);
        chk({dbrk, birq}, 2'b11);
        pulse(dclr);
        chk(dbrk, 1'b0);
        far.put(1'b1, 64);
        cyc(2);
        chk(dbrk, 1'b1);
        rexp.push_back(8'h00);
        rd(3'h6);
        chk(st[0], 1'b0);
        summarize();
    end
endmodule // tb
`default_nettype wire
